/* hw/host_cmd_pkg.sv */
package host_cmd_pkg;
  // Packet types
  localparam logic [7:0] CMD_WATCHDOG = 8'h1D;
  localparam logic [7:0] CMD_STATUS = 8'h1E;
  localparam logic [7:0] CMD_TEXT = 8'h1F;
  localparam logic [7:0] CMD_BAUD = 8'h21;
  localparam logic [7:0] CMD_PIN = 8'h22;
  localparam logic [7:0] ACK_FLAG = 8'h40;
  localparam logic [7:0] NAK_FLAG = 8'h80;
  // Packet geometry
  localparam int unsigned CMD_BYTES = 22;
  localparam int unsigned STATUS_BYTES = 15;
  localparam logic [4:0] STATUS_LEN = 5'h0F;
  localparam int unsigned WD_BYTE = 8;
  localparam logic [4:0] TEXT_MIN_LEN = 5'h03;
  localparam logic [4:0] TEXT_MAX_LEN = 5'h16;
  localparam logic [7:0] COL_MAX = 8'h13;
  localparam logic [7:0] ROW_MAX = 8'h03;
  // Pins
  localparam int unsigned PINS = 13;
  localparam int unsigned IO_PINS = 5;
  localparam int unsigned RST_PIN = 3;
  localparam logic [7:0] PIN_LIMIT = 8'h0D;
  localparam logic [7:0] VAL_MAX = 8'h64;
  localparam logic [7:0] CFG_MAX = 8'h0F;
  localparam int unsigned FUNC_BIT = 3;
  // Drive modes
  localparam logic [2:0] DM_FAST_UP_RES_DN = 3'h0;
  localparam logic [2:0] DM_FAST_BOTH = 3'h1;
  localparam logic [2:0] DM_HIZ = 3'h2;
  localparam logic [2:0] DM_RES_UP_FAST_DN = 3'h3;
  localparam logic [2:0] DM_SLOW_UP_HIZ = 3'h4;
  localparam logic [2:0] DM_SLOW_BOTH = 3'h5;
  localparam logic [2:0] DM_RESERVED = 3'h6;
  localparam logic [2:0] DM_HIZ_SLOW_DN = 3'h7;
  // Reset values
  localparam logic BAUD_115K_RESET = 1'b1;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PWM_HZ = 100;
  localparam int unsigned PWM_STEPS = 100;
  localparam int unsigned SAMPLE_HZ = 50;
  localparam int unsigned HOLD_NS = 1_000_000_000;
  localparam int unsigned STEP_CYCLES = 1_000_000_000 / (CLK_PERIOD_NS * PWM_HZ * PWM_STEPS);
  localparam int unsigned STEPS_PER_SAMPLE = PWM_HZ * PWM_STEPS / SAMPLE_HZ;
  localparam int unsigned SAMPLES_PER_SEC = SAMPLE_HZ;
  localparam int unsigned HOLD_CYCLES = HOLD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {BAUD_IDLE = 2'b01, BAUD_WAIT = 2'b10} baud_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] kind;
    logic [4:0] len;
    logic [CMD_BYTES-1:0][7:0] data;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] kind;
    logic [4:0] len;
    logic [STATUS_BYTES-1:0][7:0] data;
  } rsp_t;

  typedef struct packed {
    logic valid;
    logic [4:0] col;
    logic [1:0] row;
    logic [4:0] count;
    logic [19:0][7:0] chars;
  } text_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
    logic slow;
  } pin_bit_t;

  typedef struct packed {
    logic [IO_PINS-1:0] sync1;
    logic [IO_PINS-1:0] sync2;
    logic [PINS-1:0] samp;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;
    logic [7:0] sub_cnt;
    logic [5:0] sec_cnt;
    logic [6:0] phase;
    logic wd_armed;
    logic [7:0] wd_count;
    logic rst_active;
    logic [26:0] rst_cnt;
    logic baud_115k;
    logic baud_pending;
    baud_state_t fsm;
    rsp_t rsp;
    text_t text;
    logic [PINS-1:0][6:0] pin_val;
    logic [PINS-1:0] pin_func;
    logic [PINS-1:0][2:0] pin_mode;
    logic [PINS-1:0][4:0] drv;
  } cmd_state_t;
endpackage : host_cmd_pkg

/* hw/tick_div.sv */
`timescale 1ns/10ps
`default_nettype none
module tick_div #(
  parameter int unsigned COUNT = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  output logic o_tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // Free-running divider, one-cycle pulse at wrap
  always_comb begin
    o_tick = (cnt == 16'(COUNT - 1));
    next_cnt = o_tick ? 16'h0000 : cnt + 16'h0001;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : tick_div
`default_nettype wire

/* hw/host_cmd_watchdog_gpio_handler.sv */
// Functional notes
// - Watchdog command: one byte, zero disables, 1-255 arms for that many seconds.
// - Armed watchdog expiring without a new command resets the host.
// - Watchdog off at power-up; no second reset until host re-enables it.
// - Good reply type is request type ORed with 0x40.
// - Status read 0x1E returns 15 bytes, byte 8 is watchdog counter.
// - Status byte order: masks, options, counter, glitch delays, contrast, backlight.
// - Text request: 3-22 bytes, column 0-19, row 0-3, then characters.
// - Acknowledge at old baud rate, then switch rate.
// - Serial rate starts at 115200 baud.
// - Two bytes set value only; three also configure; index 13+ ignored.
// - Value 0 low, 100 high, 1-99 gives 100 Hz PWM duty.
// - Value acts only with function bit set and an output drive mode.
// - Function bit clear gives default function, set gives user control.
// - Pins sampled at 50 Hz with latched rising and falling flags.
// - Reported level is the sampled pin level for pins 0-4, the driven output value for pins 5-12.
// - Host reset line idles high impedance, asserts high or low.
// - Host reset is held asserted for one second.
`timescale 1ns/10ps
`default_nettype none
module host_cmd_watchdog_gpio_handler #(
  parameter int unsigned STEP_CYCLES = host_cmd_pkg::STEP_CYCLES,
  parameter int unsigned HOLD_CYCLES = host_cmd_pkg::HOLD_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire host_cmd_pkg::cmd_t i_cmd,
  output host_cmd_pkg::rsp_t o_rsp,
  input wire logic i_rsp_sent,
  input wire logic [host_cmd_pkg::STATUS_BYTES-1:0][7:0] i_status,
  output host_cmd_pkg::text_t o_text,
  output logic o_baud_115k,
  input wire logic i_rst_drive_high,
  input wire logic [host_cmd_pkg::IO_PINS-1:0] i_pin_in,
  input wire logic [host_cmd_pkg::PINS-1:0] i_dflt_o,
  input wire logic [host_cmd_pkg::PINS-1:0] i_dflt_oe,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_o,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_oe,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_pu,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_pd,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_slow,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_level,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_rise,
  output logic [host_cmd_pkg::PINS-1:0] o_pin_fall,
  input wire logic i_pin_read,
  input wire logic [7:0] i_pin_read_idx,
  output logic o_wd_armed,
  output logic [7:0] o_wd_count,
  output logic o_host_rst_active
);
  host_cmd_pkg::cmd_state_t s;
  host_cmd_pkg::cmd_state_t n;
  logic step_tick;
  logic sample_tick;
  logic sec_tick;
  logic [host_cmd_pkg::PINS-1:0] level;

  // Drive mode table: what a user pin does for a given mode and level
  function automatic host_cmd_pkg::pin_bit_t drive_of(input logic [2:0] mode, input logic hi);
    host_cmd_pkg::pin_bit_t d;
    d = '0;
    unique case (mode)
      host_cmd_pkg::DM_FAST_UP_RES_DN: begin
        d.o = hi;
        d.oe = hi;
        d.pd = !hi;
      end
      host_cmd_pkg::DM_FAST_BOTH: begin
        d.o = hi;
        d.oe = 1'b1;
      end
      host_cmd_pkg::DM_RES_UP_FAST_DN: begin
        d.pu = hi;
        d.oe = !hi;
      end
      host_cmd_pkg::DM_SLOW_UP_HIZ: begin
        d.o = hi;
        d.oe = hi;
        d.slow = 1'b1;
      end
      host_cmd_pkg::DM_SLOW_BOTH: begin
        d.o = hi;
        d.oe = 1'b1;
        d.slow = 1'b1;
      end
      host_cmd_pkg::DM_HIZ_SLOW_DN: begin
        d.oe = !hi;
        d.slow = 1'b1;
      end
      default: d = '0; // Input and reserved modes float, value ignored
    endcase
    return d;
  endfunction : drive_of

  tick_div #(.COUNT(STEP_CYCLES)) u_step (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .o_tick(step_tick)
  );

  // Slower rates derived from the PWM step so all ticks stay phase-locked
  assign sample_tick = step_tick && (s.sub_cnt == 8'(host_cmd_pkg::STEPS_PER_SAMPLE - 1));
  assign sec_tick = sample_tick && (s.sec_cnt == 6'(host_cmd_pkg::SAMPLES_PER_SEC - 1));
  assign level = {o_pin_o[host_cmd_pkg::PINS-1:host_cmd_pkg::IO_PINS], s.sync2};

  // Next-state logic for the whole block
  always_comb begin
    host_cmd_pkg::pin_bit_t d;
    logic [7:0] idx;
    d = '0;
    idx = i_cmd.data[0];
    n = s;
    n.rsp.valid = 1'b0;
    n.text.valid = 1'b0;
    n.sync1 = i_pin_in;
    n.sync2 = s.sync1;
    if (step_tick) begin
      n.phase = (s.phase == 7'(host_cmd_pkg::PWM_STEPS - 1)) ? 7'h00 : s.phase + 7'h01;
      n.sub_cnt = sample_tick ? 8'h00 : s.sub_cnt + 8'h01;
    end
    if (sample_tick) begin
      n.sec_cnt = sec_tick ? 6'h00 : s.sec_cnt + 6'h01;
    end
    // Clear on read first so a same-cycle edge still sets the flag
    if (i_pin_read && i_pin_read_idx < host_cmd_pkg::PIN_LIMIT) begin
      n.rise[i_pin_read_idx[3:0]] = 1'b0;
      n.fall[i_pin_read_idx[3:0]] = 1'b0;
    end
    if (sample_tick) begin
      n.samp = level;
      n.rise = n.rise | (level & ~s.samp);
      n.fall = n.fall | (~level & s.samp);
    end
    // Watchdog countdown; expiry fires one reset and disarms
    if (sec_tick && s.wd_armed) begin
      n.wd_count = s.wd_count - 8'h01;
      if (s.wd_count == 8'h01) begin
        n.wd_armed = 1'b0;
        n.rst_active = 1'b1;
        n.rst_cnt = '0;
      end
    end
    if (s.rst_active) begin
      n.rst_cnt = s.rst_cnt + 27'h0000001;
      if (s.rst_cnt == 27'(HOLD_CYCLES - 1)) begin
        n.rst_active = 1'b0;
      end
    end
    // Baud switch waits for the acknowledge to leave the wire
    unique case (s.fsm)
      host_cmd_pkg::BAUD_IDLE: ;
      host_cmd_pkg::BAUD_WAIT: begin
        if (i_rsp_sent) begin
          n.baud_115k = s.baud_pending;
          n.fsm = host_cmd_pkg::BAUD_IDLE;
        end
      end
    endcase
    // Command decode; a malformed request gets a negative reply
    if (i_cmd.valid) begin
      n.rsp.valid = 1'b1;
      n.rsp.kind = i_cmd.kind | host_cmd_pkg::NAK_FLAG;
      n.rsp.len = 5'h00;
      n.rsp.data = '0;
      case (i_cmd.kind)
        host_cmd_pkg::CMD_WATCHDOG: begin
          if (i_cmd.len == 5'h01) begin
            n.wd_count = idx;
            n.wd_armed = (idx != 8'h00);
            n.rsp.kind = i_cmd.kind | host_cmd_pkg::ACK_FLAG;
          end
        end
        host_cmd_pkg::CMD_STATUS: begin
          if (i_cmd.len == 5'h00) begin
            n.rsp.kind = i_cmd.kind | host_cmd_pkg::ACK_FLAG;
            n.rsp.len = host_cmd_pkg::STATUS_LEN;
            n.rsp.data = i_status;
            n.rsp.data[host_cmd_pkg::WD_BYTE] = s.wd_count;
          end
        end
        host_cmd_pkg::CMD_TEXT: begin
          if (i_cmd.len >= host_cmd_pkg::TEXT_MIN_LEN && i_cmd.len <= host_cmd_pkg::TEXT_MAX_LEN
              && idx <= host_cmd_pkg::COL_MAX && i_cmd.data[1] <= host_cmd_pkg::ROW_MAX) begin
            n.text.valid = 1'b1;
            n.text.col = idx[4:0];
            n.text.row = i_cmd.data[1][1:0];
            n.text.count = i_cmd.len - 5'h02;
            n.text.chars = i_cmd.data[21:2];
            n.rsp.kind = i_cmd.kind | host_cmd_pkg::ACK_FLAG;
          end
        end
        host_cmd_pkg::CMD_BAUD: begin
          if (i_cmd.len == 5'h01 && idx <= 8'h01 && s.fsm == host_cmd_pkg::BAUD_IDLE) begin
            n.baud_pending = idx[0];
            n.fsm = host_cmd_pkg::BAUD_WAIT;
            n.rsp.kind = i_cmd.kind | host_cmd_pkg::ACK_FLAG;
          end
        end
        host_cmd_pkg::CMD_PIN: begin
          if ((i_cmd.len == 5'h02 || (i_cmd.len == 5'h03
              && i_cmd.data[2] <= host_cmd_pkg::CFG_MAX)) && i_cmd.data[1] <= host_cmd_pkg::VAL_MAX) begin
            n.rsp.kind = i_cmd.kind | host_cmd_pkg::ACK_FLAG;
            if (idx < host_cmd_pkg::PIN_LIMIT) begin
              n.pin_val[idx[3:0]] = i_cmd.data[1][6:0];
              if (i_cmd.len == 5'h03) begin
                n.pin_func[idx[3:0]] = i_cmd.data[2][host_cmd_pkg::FUNC_BIT];
                n.pin_mode[idx[3:0]] = i_cmd.data[2][2:0];
              end
            end
          end
        end
        default: ;
      endcase
    end
    // Pin drivers: user control or default function
    for (int i = 0; i < host_cmd_pkg::PINS; i++) begin
      if (s.pin_func[i]) begin
        d = drive_of(s.pin_mode[i], s.pin_val[i] > s.phase);
      end else if (i == host_cmd_pkg::RST_PIN) begin
        d = '0;
        d.o = i_rst_drive_high;
        d.oe = s.rst_active;
      end else begin
        d = '0;
        d.o = i_dflt_o[i];
        d.oe = i_dflt_oe[i];
      end
      n.drv[i] = d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.baud_115k <= host_cmd_pkg::BAUD_115K_RESET;
      s.baud_pending <= host_cmd_pkg::BAUD_115K_RESET;
      s.fsm <= host_cmd_pkg::BAUD_IDLE;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state
  always_comb begin
    for (int i = 0; i < host_cmd_pkg::PINS; i++) begin
      {o_pin_o[i], o_pin_oe[i], o_pin_pu[i], o_pin_pd[i], o_pin_slow[i]} = s.drv[i];
    end
  end
  assign o_rsp = s.rsp;
  assign o_text = s.text;
  assign o_baud_115k = s.baud_115k;
  assign o_pin_level = s.samp;
  assign o_pin_rise = s.rise;
  assign o_pin_fall = s.fall;
  assign o_wd_armed = s.wd_armed;
  assign o_wd_count = s.wd_count;
  assign o_host_rst_active = s.rst_active;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  wd_disable_a: assert property (i_cmd.valid && !sec_tick && i_cmd.kind == 8'h1D
      && i_cmd.len == 5'h01 && i_cmd.data[0] == 8'h00 |=> !s.wd_armed ##1 !$rose(s.rst_active))
    else $error("watchdog not disabled by zero timeout");
  wd_expire_a: assert property (s.wd_armed && s.wd_count == 8'h01 && sec_tick
      && !i_cmd.valid |=> s.rst_active && !s.wd_armed && o_wd_count == 8'h00)
    else $error("watchdog expiry did not reset host");
  wd_single_a: assert property (!s.wd_armed && !s.rst_active |=> !s.rst_active)
    else $error("host reset without armed watchdog");
  ack_type_a: assert property (i_cmd.valid && i_cmd.kind == host_cmd_pkg::CMD_WATCHDOG
      && i_cmd.len == 5'h01 |=> o_rsp.valid && o_rsp.kind == 8'h5D && o_rsp.len == 5'h00)
    else $error("watchdog acknowledge type wrong");
  status_byte_a: assert property (i_cmd.valid && i_cmd.kind == host_cmd_pkg::CMD_STATUS
      && i_cmd.len == 5'h00 |=> o_rsp.len == 5'h0F && o_rsp.data[8] == $past(s.wd_count))
    else $error("status reply length or counter byte wrong");
  text_range_a: assert property (o_text.valid |-> o_text.col <= 5'h13
      && o_text.count >= 5'h01 && o_text.count <= 5'h14)
    else $error("text placement out of range");
  baud_hold_a: assert property (s.fsm == host_cmd_pkg::BAUD_WAIT && !i_rsp_sent
      |=> $stable(o_baud_115k))
    else $error("baud changed before acknowledge sent");
  pin_ignore_a: assert property (i_cmd.valid && i_cmd.kind == host_cmd_pkg::CMD_PIN
      && i_cmd.data[0] >= 8'h0D |=> $stable(s.pin_val) && $stable(s.pin_func))
    else $error("out-of-range pin index modified state");
  pwm_low_a: assert property (s.pin_func[5] && s.pin_mode[5] == 3'h1
      && s.pin_val[5] == 7'h00 |=> !o_pin_o[5] && o_pin_oe[5])
    else $error("zero value did not drive pin low");
  rst_hold_a: assert property ($rose(s.rst_active) |-> s.rst_active[*8] ##1
      (s.rst_cnt > 27'h0000007 || !s.rst_active))
    else $error("host reset released early");
  edge_clear_a: assert property (i_pin_read && i_pin_read_idx == 8'h00 && !sample_tick
      |=> !o_pin_rise[0] && !o_pin_fall[0])
    else $error("edge flags not cleared on read");

  wd_fire_c: cover property (s.wd_armed ##1 $rose(s.rst_active));
  baud_switch_c: cover property (s.fsm == host_cmd_pkg::BAUD_WAIT ##1 i_rsp_sent);
  text_c: cover property (o_text.valid && o_text.count == 5'h14);
  pwm_c: cover property (s.pin_func[5] && s.pin_val[5] == 7'h32 ##1 o_pin_o[5]);
endmodule : host_cmd_watchdog_gpio_handler
`default_nettype wire

/* tb/host_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire host_cmd_pkg::cmd_t i_cmd,
  input wire host_cmd_pkg::rsp_t i_rsp,
  output logic o_rsp_sent,
  output logic o_host_115k
);
  logic [5:0] wait_cnt;
  logic cand_115k;
  logic want_115k;
  logic ack_seen;
  // Reply takes a few or many cycles on the wire; a newer reply restarts it
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_cnt <= 6'h00;
      o_rsp_sent <= 1'b0;
      cand_115k <= 1'b1;
      want_115k <= 1'b1;
      ack_seen <= 1'b0;
      o_host_115k <= 1'b1;
    end else begin
      o_rsp_sent <= (wait_cnt == 6'h01);
      if (i_cmd.valid && i_cmd.kind == host_cmd_pkg::CMD_BAUD) begin
        cand_115k <= i_cmd.data[0][0];
      end
      if (i_rsp.valid) begin
        wait_cnt <= i_slow ? 6'h28 : 6'h02;
      end else if (wait_cnt != 6'h00) begin
        wait_cnt <= wait_cnt - 6'h01;
      end
      // Only a positive baud acknowledge arms the host's own switch
      if (i_rsp.valid && i_rsp.kind == 8'h61) begin
        ack_seen <= 1'b1;
        want_115k <= cand_115k;
      end else if (wait_cnt == 6'h01) begin
        ack_seen <= 1'b0;
      end
      if (wait_cnt == 6'h01 && ack_seen) begin
        o_host_115k <= want_115k;
      end
    end
  end
endmodule : host_link_model
`default_nettype wire

/* tb/host_cmd_watchdog_gpio_handler_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", s, e, g); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < lim) begin cyc(1); n++; end \
  if (n >= lim) begin miscompares++; $display("[ERR] wait exp 1 got 0"); print_verdict(); end end
module host_cmd_watchdog_gpio_handler_tb;
  localparam int unsigned STEP = 2;
  localparam int unsigned HOLD = 20;
  localparam logic [7:0][4:0] DRV_HI = {5'h01, 5'h00, 5'h19, 5'h19, 5'h04, 5'h00, 5'h18, 5'h18};
  localparam logic [7:0][4:0] DRV_LO = {5'h09, 5'h00, 5'h09, 5'h01, 5'h08, 5'h00, 5'h08, 5'h02};
  localparam logic [2:0][7:0] DUTY = {8'h63, 8'h32, 8'h01};
  logic clk, rstn, rsp_sent, slow, rst_hi, pin_read, host_115k, baud, armed, rst_act;
  logic [7:0] read_idx, wd_count;
  host_cmd_pkg::cmd_t cmd;
  host_cmd_pkg::rsp_t rsp;
  host_cmd_pkg::text_t text;
  logic [14:0][7:0] status;
  logic [4:0] pin_in;
  logic [12:0] dflt_o, dflt_oe, p_o, p_oe, p_pu, p_pd, p_slow, level, rise, fall;
  int miscompares, check_count, n, cnt;

  host_cmd_watchdog_gpio_handler #(.STEP_CYCLES(STEP), .HOLD_CYCLES(HOLD))
    host_cmd_watchdog_gpio_handler_i (.i_core_clk(clk), .i_rstn(rstn), .i_cmd(cmd),
    .o_rsp(rsp), .i_rsp_sent(rsp_sent), .i_status(status), .o_text(text),
    .o_baud_115k(baud), .i_rst_drive_high(rst_hi), .i_pin_in(pin_in), .i_dflt_o(dflt_o),
    .i_dflt_oe(dflt_oe), .o_pin_o(p_o), .o_pin_oe(p_oe), .o_pin_pu(p_pu), .o_pin_pd(p_pd),
    .o_pin_slow(p_slow), .o_pin_level(level), .o_pin_rise(rise), .o_pin_fall(fall),
    .i_pin_read(pin_read), .i_pin_read_idx(read_idx), .o_wd_armed(armed),
    .o_wd_count(wd_count), .o_host_rst_active(rst_act));

  host_link_model host_link_model_i (.i_core_clk(clk), .i_rstn(rstn), .i_slow(slow),
    .i_cmd(cmd), .i_rsp(rsp), .o_rsp_sent(rsp_sent), .o_host_115k(host_115k));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  // One request packet, then the one-cycle reply is checked for its type
  task automatic send(input logic [7:0] k, input logic [4:0] len, input logic [7:0] b0,
                      input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] exk);
    @(posedge clk);
    cmd.valid <= 1'b1;
    cmd.kind <= k;
    cmd.len <= len;
    cmd.data[0] <= b0;
    cmd.data[1] <= b1;
    cmd.data[2] <= b2;
    for (int i = 3; i < 22; i++) cmd.data[i] <= 8'h41 + 8'(i);
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    `CHK("rsp valid", 1'b1, rsp.valid)
    `CHK("rsp kind", exk, rsp.kind)
  endtask : send

  task print_verdict;
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence; pin 1 has a live default drive, pin 3 must ignore its own
  initial begin
    rstn = 1'b0;
    cmd = '0;
    for (int i = 0; i < 15; i++) status[i] = 8'hA0 + 8'(i);
    slow = 1'b0;
    rst_hi = 1'b1;
    pin_read = 1'b0;
    read_idx = 8'h00;
    pin_in = 5'h00;
    dflt_o = 13'h0002;
    dflt_oe = 13'h000A;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
    `CHK("baud 115k", 1'b1, baud)
    `CHK("wd armed", 1'b0, armed)
    `CHK("reset line oe", 1'b0, p_oe[3])
    `CHK("default drive", 2'b11, {p_oe[1], p_o[1]})
    // Watchdog arm, status read-back, disarm
    send(host_cmd_pkg::CMD_WATCHDOG, 5'h01, 8'h05, 8'h00, 8'h00, 8'h5D);
    `CHK("wd len", 5'h00, rsp.len)
    `CHK("wd state", 9'h105, {armed, wd_count})
    send(host_cmd_pkg::CMD_STATUS, 5'h00, 8'h00, 8'h00, 8'h00, 8'h5E);
    `CHK("status len", 5'h0F, rsp.len)
    for (int i = 0; i < 15; i++) `CHK("status byte", (i == 8) ? 8'h05 : 8'hA0 + 8'(i), rsp.data[i])
    // Host re-arms inside each window shorter than one second, so no reset may come
    cnt = 0;
    for (int k = 0; k < 2; k++) begin
      send(host_cmd_pkg::CMD_WATCHDOG, 5'h01, 8'h02, 8'h00, 8'h00, 8'h5D);
      repeat (19000) begin cyc(1); cnt += int'(rst_act !== 1'b0); end
    end
    `CHK("rearmed no reset", 0, cnt)
    `CHK("rearmed armed", 1'b1, armed)
    send(host_cmd_pkg::CMD_WATCHDOG, 5'h01, 8'h00, 8'h00, 8'h00, 8'h5D);
    `CHK("wd off", 1'b0, armed)
    // Text placement at the far corner with a full line, then a minimal good request and the bad cases
    send(host_cmd_pkg::CMD_TEXT, 5'h16, 8'h13, 8'h03, 8'h7E, 8'h5F);
    `CHK("text pos", {1'b1, 5'h13, 2'h3, 5'h14}, {text.valid, text.col, text.row, text.count})
    `CHK("text chars", 16'h7E56, {text.chars[0], text.chars[19]})
    send(host_cmd_pkg::CMD_TEXT, 5'h03, 8'h00, 8'h00, 8'h20, 8'h5F);
    send(host_cmd_pkg::CMD_TEXT, 5'h03, 8'h14, 8'h00, 8'h20, 8'h9F);
    send(host_cmd_pkg::CMD_TEXT, 5'h03, 8'h00, 8'h04, 8'h20, 8'h9F);
    send(host_cmd_pkg::CMD_TEXT, 5'h02, 8'h00, 8'h00, 8'h20, 8'h9F);
    send(host_cmd_pkg::CMD_TEXT, 5'h17, 8'h00, 8'h00, 8'h20, 8'h9F);
    send(8'h30, 5'h00, 8'h00, 8'h00, 8'h00, 8'hB0);
    // Baud change with a slow line; a second request meanwhile is refused
    slow <= 1'b1;
    send(host_cmd_pkg::CMD_BAUD, 5'h01, 8'h00, 8'h00, 8'h00, 8'h61);
    `CHK("baud held", 1'b1, baud)
    send(host_cmd_pkg::CMD_BAUD, 5'h01, 8'h01, 8'h00, 8'h00, 8'hA1);
    `WAITC(baud === 1'b0, 100)
    `CHK("host rate", 1'b0, host_115k)
    send(host_cmd_pkg::CMD_BAUD, 5'h01, 8'h02, 8'h00, 8'h00, 8'hA1);
    slow <= 1'b0;
    send(host_cmd_pkg::CMD_BAUD, 5'h01, 8'h01, 8'h00, 8'h00, 8'h61);
    `WAITC(baud === 1'b1, 100)
    // Every drive mode with output high, then a value-only change to low
    for (int m = 0; m < 8; m++) begin
      send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h05, 8'h64, 8'h08 | 8'(m), 8'h62);
      cyc(1);
      `CHK("drive hi", DRV_HI[m], {p_o[5], p_oe[5], p_pu[5], p_pd[5], p_slow[5]})
      send(host_cmd_pkg::CMD_PIN, 5'h02, 8'h05, 8'h00, 8'h00, 8'h62);
      cyc(1);
      `CHK("drive lo", DRV_LO[m], {p_o[5], p_oe[5], p_pu[5], p_pd[5], p_slow[5]})
    end
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h05, 8'h64, 8'h01, 8'h62);
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h0D, 8'h64, 8'h09, 8'h62);
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'hFF, 8'h64, 8'h09, 8'h62);
    cyc(1);
    `CHK("pin oe set", 13'h0002, p_oe)
    send(host_cmd_pkg::CMD_PIN, 5'h02, 8'h05, 8'h65, 8'h00, 8'hA2);
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h05, 8'h00, 8'h10, 8'hA2);
    send(host_cmd_pkg::CMD_PIN, 5'h01, 8'h05, 8'h00, 8'h00, 8'hA2);
    // Duty over one full PWM period of 100 steps
    for (int j = 0; j < 3; j++) begin
      send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h05, DUTY[j], 8'h09, 8'h62);
      cyc(2);
      cnt = 0;
      repeat (100 * STEP) begin cyc(1); cnt += int'(p_o[5]); end
      `CHK("pwm high", int'(DUTY[j]) * STEP, cnt)
    end
    // Pin 0 commanded low yet pulled high outside; LED pin 5 fully on
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h05, 8'h64, 8'h09, 8'h62);
    send(host_cmd_pkg::CMD_PIN, 5'h03, 8'h00, 8'h00, 8'h0A, 8'h62);
    @(posedge clk);
    pin_in <= 5'h01;
    `WAITC(level[0] === 1'b1, 2000)
    `CHK("level vs cmd", 3'b110, {level[5], rise[0], p_o[0]})
    @(posedge clk);
    pin_in <= 5'h00;
    `WAITC(level[0] === 1'b0, 2000)
    @(posedge clk);
    pin_in <= 5'h01;
    `WAITC(level[0] === 1'b1, 2000)
    `CHK("edge flags", 2'b11, {rise[0], fall[0]})
    @(posedge clk);
    pin_read <= 1'b1;
    @(posedge clk);
    pin_read <= 1'b0;
    cyc(1);
    `CHK("flags cleared", 2'b00, {rise[0], fall[0]})
    // One-second watchdog runs out; reset pulse length and release
    send(host_cmd_pkg::CMD_WATCHDOG, 5'h01, 8'h01, 8'h00, 8'h00, 8'h5D);
    `WAITC(rst_act === 1'b1, 25000)
    `CHK("wd expired", 9'h000, {armed, wd_count})
    cyc(1);
    `CHK("reset drive", 2'b11, {p_oe[3], p_o[3]})
    rst_hi <= 1'b0;
    cyc(1);
    `CHK("reset drive low", 2'b10, {p_oe[3], p_o[3]})
    n = 3;
    while (rst_act === 1'b1 && n < 100) begin cyc(1); n++; end
    `CHK("hold cycles", int'(HOLD), n - 1)
    cyc(1);
    `CHK("reset released", 1'b0, p_oe[3])
    cnt = 0;
    repeat (25000) begin cyc(1); cnt += int'(rst_act !== 1'b0); end
    `CHK("no second reset", 0, cnt)
    print_verdict();
  end
endmodule : host_cmd_watchdog_gpio_handler_tb
`default_nettype wire
